// file: panel_consts.vh
// Constants for the drive operator panel logic
//
// Behaviour
// - Run lamp on while running, else off
// - Source lamp: panel off, terminal on, comms blink
// - Direction lamp on for reverse rotation
// - Torque lamp: steady torque, slow tune, fast fault
// - Five-digit display shows frequencies, monitors, faults
// - Menu levels: group, code, setting value
// - Menu key enters or leaves group level
// - Confirm at value: store, back, next code
// - Menu key at value: discard, same code
// - Up/down keys raise or lower value or code
// - Shift steps status view or edited digit
// - Run key starts only under panel control
// - Halt key stops or clears fault, scope-limited
// - Multifunction key switches source or direction
// - Locked or read-only codes: no blink, no edit
// - One mask bit enables each status parameter, bar stop parameter 0 and run parameters 0..4
// - Stopped: up to thirteen parameters, stop mask
// - Running: five defaults plus two run masks
// - Shown parameter survives power loss
// - Source codes panel 0, terminal 1, comms 2
`ifndef PANEL_CONSTS_VH
`define PANEL_CONSTS_VH

// Register byte offsets
`define REG_CONFIG 8'h00
`define REG_RUN_MASK 8'h04
`define REG_STOP_MASK 8'h08
`define REG_LOCK 8'h0C
`define REG_STATUS 8'h10
`define REG_EDIT 8'h14

// Config field positions and reset values
`define CFG_SRC_LSB 0
`define CFG_MULTI_LSB 4
`define CFG_SCOPE_BIT 8
`define CFG_RESET 32'h0000_0000
`define RUN_MASK_RESET 32'h0000_0000
`define STOP_MASK_RESET 13'h0001
`define LOCK_RESET 32'h0000_0000

// Command source codes
`define SRC_PANEL 2'h0
`define SRC_TERMINAL 2'h1
`define SRC_COMMS 2'h2

// Multifunction key settings
`define MULTI_NONE 3'h0
`define MULTI_SOURCE 3'h1
`define MULTI_DIRECTION 3'h2

// Key positions in the key vector
`define KEY_MENU 0
`define KEY_ENTER 1
`define KEY_UP 2
`define KEY_DOWN 3
`define KEY_SHIFT 4
`define KEY_RUN 5
`define KEY_HALT 6
`define KEY_MULTI 7

// Display layout
`define DIGITS 5
`define STOP_PARAMS 13
`define RUN_DEFAULTS 32'h0000_001F

// Blink timing
`define CLK_KHZ 20000
`define SLOW_HALF_MS 500
`define FAST_HALF_MS 125

`endif

// file: blink_divider.v
// Free-running divider that toggles a blink level
`timescale 1ns/1ns
module blink_divider #(
   parameter HALF_CYCLES = 1000
) (
   input wire clk,
   input wire sys_rst,
   output reg blink
);
   reg [23:0] count; // Cycles since last toggle

   // Toggle the level every half period
   always @(posedge clk) begin
      if (sys_rst) begin
         count <= 24'h000000;
         blink <= 1'b0;
      end else if (count >= HALF_CYCLES - 1) begin
         count <= 24'h000000;
         blink <= ~blink;
      end else begin
         count <= count + 24'h000001;
      end
   end
endmodule

// file: param_mem.v
// Setting value store for all function codes
`timescale 1ns/1ns
module param_mem (
   input wire clk,
   input wire wr_en,
   input wire [7:0] wr_addr,
   input wire [19:0] wr_data,
   input wire [7:0] rd_addr,
   output reg [19:0] rd_data
);
   reg [19:0] mem [0:255]; // One word per group and code
   integer i; // Word index for power-on clear

   // Start every setting at zero so an edit never loads unknowns
   initial begin
      for (i = 0; i < 256; i = i + 1) begin
         mem[i] = 20'h00000;
      end
   end

   // Write port and registered read port
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// file: panel_logic.v
// Operator panel: keys, menus, lamps, display and APB registers
`timescale 1ns/1ns
`include "panel_consts.vh"
module panel_logic #(
   parameter SLOW_HALF = `SLOW_HALF_MS * `CLK_KHZ,
   parameter FAST_HALF = `FAST_HALF_MS * `CLK_KHZ
) (
   input wire clk,
   input wire sys_rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Keypad pins, high while pressed
   input wire menu_key,
   input wire enter_key,
   input wire up_key,
   input wire down_key,
   input wire shift_key,
   input wire run_key,
   input wire halt_reset_key,
   input wire multifunction_key,
   // Drive core status
   input wire drive_running,
   input wire drive_reverse,
   input wire drive_fault,
   input wire torque_mode,
   input wire auto_tuning,
   input wire [19:0] status_value,
   input wire [19:0] fault_code,
   input wire [4:0] saved_view,
   // Lamps
   output reg run_lamp,
   output reg control_source_lamp,
   output reg direction_lamp,
   output reg tune_torque_lamp,
   // Display
   output reg [19:0] display_digits,
   output reg [4:0] display_blink,
   output reg [4:0] view_index,
   // Commands to the drive core
   output reg start_request,
   output reg stop_request,
   output reg fault_reset,
   output reg direction_toggle,
   output reg [1:0] active_source,
   output reg param_write,
   output reg [7:0] param_addr,
   output reg [19:0] param_data
);
   // Menu states, one-hot
   localparam [3:0] ST_VIEW = 4'h1;
   localparam [3:0] ST_GROUP = 4'h2;
   localparam [3:0] ST_CODE = 4'h4;
   localparam [3:0] ST_VALUE = 4'h8;

   // Software settings
   reg [1:0] command_source_select; // Chosen command source
   reg [2:0] multikey_function_setting; // Multifunction key use
   reg halt_key_scope; // Halt key works in every source
   reg [15:0] run_display_mask_low; // Run parameters 0..15
   reg [15:0] run_display_mask_high; // Run parameters 16..31
   reg [12:0] stop_display_mask; // Stop parameters 0..12
   reg [15:0] readonly_groups; // Groups that are never editable
   reg [15:0] runlock_groups; // Groups frozen while running

   // Panel state
   reg [3:0] state; // Menu level
   reg [3:0] group; // Selected function code group
   reg [3:0] code; // Selected function code
   reg [19:0] edit_value; // Value under edit
   reg [2:0] edit_digit; // Digit under edit
   reg panel_override; // Quick switch to panel control
   reg restore_pending; // Reload shown parameter after reset

   // Key synchronisers and edge detect
   reg [7:0] key_meta; // First stage
   reg [7:0] key_sync; // Second stage
   reg [7:0] key_prev; // Last synchronised level
   wire [7:0] key_pins;
   wire [7:0] press;

   // Memory and blink wires
   wire [19:0] mem_rd_data;
   wire slow_blink;
   wire fast_blink;

   // Derived terms
   wire apb_access;
   wire [1:0] eff_source;
   wire locked;
   wire [31:0] view_enable;
   wire [3:0] cur_digit;

   assign key_pins = {multifunction_key, halt_reset_key, run_key, shift_key,
                      down_key, up_key, enter_key, menu_key};
   assign press = key_sync & ~key_prev;
   assign apb_access = psel & penable & pready;
   // Override forces panel control while set
   assign eff_source = panel_override ? `SRC_PANEL : command_source_select;
   assign locked = readonly_groups[group] | (drive_running & runlock_groups[group]);
   // Stop view uses its own mask plus parameter 0, run view adds five defaults
   assign view_enable = drive_running ?
      ({run_display_mask_high, run_display_mask_low} | `RUN_DEFAULTS) :
      {19'h00000, stop_display_mask | 13'h0001};
   assign cur_digit = edit_value[edit_digit * 4 +: 4];

   // Next enabled status parameter after the current one
   function [4:0] next_view;
      input [4:0] cur;
      input [31:0] en;
      integer i;
      reg [4:0] k;
      reg found;
      begin
         next_view = cur;
         found = 1'b0;
         for (i = 1; i <= 32; i = i + 1) begin
            k = cur + i[4:0];
            if (!found && en[k]) begin
               next_view = k;
               found = 1'b1;
            end
         end
      end
   endfunction

   // Decimal step of one digit with wrap
   function [3:0] bcd_step;
      input [3:0] d;
      input up;
      begin
         if (up) begin
            bcd_step = (d >= 4'h9) ? 4'h0 : d + 4'h1;
         end else begin
            bcd_step = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
         end
      end
   endfunction

   // Setting value store
   param_mem u_mem (
      .clk(clk),
      .wr_en(param_write),
      .wr_addr(param_addr),
      .wr_data(param_data),
      .rd_addr({group, code}),
      .rd_data(mem_rd_data)
   );

   // Slow and fast blink levels
   blink_divider #(.HALF_CYCLES(SLOW_HALF)) u_slow (
      .clk(clk),
      .sys_rst(sys_rst),
      .blink(slow_blink)
   );

   blink_divider #(.HALF_CYCLES(FAST_HALF)) u_fast (
      .clk(clk),
      .sys_rst(sys_rst),
      .blink(fast_blink)
   );

   // Two-stage synchroniser on key pins
   always @(posedge clk) begin
      if (sys_rst) begin
         key_meta <= 8'h00;
         key_sync <= 8'h00;
         key_prev <= 8'h00;
      end else begin
         key_meta <= key_pins;
         key_sync <= key_meta;
         key_prev <= key_sync;
      end
   end

   // APB slave: one wait-free access phase
   always @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         command_source_select <= `SRC_PANEL;
         multikey_function_setting <= `MULTI_NONE;
         halt_key_scope <= 1'b0;
         {run_display_mask_high, run_display_mask_low} <= `RUN_MASK_RESET;
         stop_display_mask <= `STOP_MASK_RESET;
         {runlock_groups, readonly_groups} <= `LOCK_RESET;
      end else begin
         // Answer in the first access cycle
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel & ~penable) begin
            case (paddr)
               `REG_CONFIG: prdata <= {23'h000000, halt_key_scope, 1'b0,
                  multikey_function_setting, 2'h0, command_source_select};
               `REG_RUN_MASK: prdata <= {run_display_mask_high, run_display_mask_low};
               `REG_STOP_MASK: prdata <= {19'h00000, stop_display_mask};
               `REG_LOCK: prdata <= {runlock_groups, readonly_groups};
               `REG_STATUS: prdata <= {9'h000, edit_digit, code, group, eff_source,
                  panel_override, view_index, state};
               `REG_EDIT: prdata <= {12'h000, edit_value};
               default: pslverr <= 1'b1; // Unmapped address
            endcase
         end
         // Writes land at the completing edge
         if (apb_access & pwrite) begin
            case (paddr)
               `REG_CONFIG: begin
                  command_source_select <= pwdata[`CFG_SRC_LSB +: 2];
                  multikey_function_setting <= pwdata[`CFG_MULTI_LSB +: 3];
                  halt_key_scope <= pwdata[`CFG_SCOPE_BIT];
               end
               `REG_RUN_MASK: begin
                  run_display_mask_low <= pwdata[15:0];
                  run_display_mask_high <= pwdata[31:16];
               end
               `REG_STOP_MASK: stop_display_mask <= pwdata[12:0];
               `REG_LOCK: begin
                  readonly_groups <= pwdata[15:0];
                  runlock_groups <= pwdata[31:16];
               end
               default: begin
                  // Read-only or unmapped: ignored
               end
            endcase
         end
      end
   end

   // Menu state machine and editing
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_VIEW;
         group <= 4'h0;
         code <= 4'h0;
         edit_value <= 20'h00000;
         edit_digit <= 3'h0;
         view_index <= 5'h00;
         restore_pending <= 1'b1;
         param_write <= 1'b0;
         param_addr <= 8'h00;
         param_data <= 20'h00000;
      end else begin
         param_write <= 1'b0;
         if (restore_pending) begin
            // First cycle after release: restore shown parameter
            view_index <= saved_view;
            restore_pending <= 1'b0;
         end else begin
            case (state)
               ST_VIEW: begin
                  if (press[`KEY_MENU]) begin
                     state <= ST_GROUP;
                  end else if (press[`KEY_SHIFT]) begin
                     view_index <= next_view(view_index, view_enable);
                  end
               end
               ST_GROUP: begin
                  if (press[`KEY_MENU]) begin
                     state <= ST_VIEW;
                  end else if (press[`KEY_ENTER]) begin
                     state <= ST_CODE;
                     code <= 4'h0;
                  end else if (press[`KEY_UP]) begin
                     group <= group + 4'h1;
                  end else if (press[`KEY_DOWN]) begin
                     group <= group - 4'h1;
                  end
               end
               ST_CODE: begin
                  if (press[`KEY_MENU]) begin
                     state <= ST_GROUP;
                  end else if (press[`KEY_ENTER]) begin
                     // Registered read already holds this code
                     state <= ST_VALUE;
                     edit_value <= mem_rd_data;
                     edit_digit <= 3'h0;
                  end else if (press[`KEY_UP]) begin
                     code <= code + 4'h1;
                  end else if (press[`KEY_DOWN]) begin
                     code <= code - 4'h1;
                  end
               end
               ST_VALUE: begin
                  if (press[`KEY_MENU]) begin
                     state <= ST_CODE;
                  end else if (press[`KEY_ENTER]) begin
                     // Store, then step to the following code
                     if (!locked) begin
                        param_write <= 1'b1;
                        param_addr <= {group, code};
                        param_data <= edit_value;
                     end
                     state <= ST_CODE;
                     code <= code + 4'h1;
                  end else if (!locked) begin
                     if (press[`KEY_UP] | press[`KEY_DOWN]) begin
                        edit_value[edit_digit * 4 +: 4] <=
                           bcd_step(cur_digit, press[`KEY_UP]);
                     end else if (press[`KEY_SHIFT]) begin
                        edit_digit <= (edit_digit == 3'h4) ? 3'h0 :
                           edit_digit + 3'h1;
                     end
                  end
               end
               default: state <= ST_VIEW;
            endcase
         end
      end
   end

   // Run, halt and multifunction keys
   always @(posedge clk) begin
      if (sys_rst) begin
         start_request <= 1'b0;
         stop_request <= 1'b0;
         fault_reset <= 1'b0;
         direction_toggle <= 1'b0;
         panel_override <= 1'b0;
         active_source <= `SRC_PANEL;
      end else begin
         start_request <= press[`KEY_RUN] & (eff_source == `SRC_PANEL) & ~drive_fault;
         stop_request <= 1'b0;
         fault_reset <= 1'b0;
         direction_toggle <= 1'b0;
         active_source <= eff_source;
         // Scope 0 limits halt key to panel control
         if (press[`KEY_HALT] & (halt_key_scope | (eff_source == `SRC_PANEL))) begin
            if (drive_fault) begin
               fault_reset <= 1'b1;
            end else if (drive_running) begin
               stop_request <= 1'b1;
            end
         end
         if (press[`KEY_MULTI]) begin
            case (multikey_function_setting)
               `MULTI_SOURCE: panel_override <= ~panel_override;
               `MULTI_DIRECTION: direction_toggle <= 1'b1;
               default: begin
                  // No function assigned
               end
            endcase
         end
      end
   end

   // Lamps and display
   always @(posedge clk) begin
      if (sys_rst) begin
         run_lamp <= 1'b0;
         control_source_lamp <= 1'b0;
         direction_lamp <= 1'b0;
         tune_torque_lamp <= 1'b0;
         display_digits <= 20'h00000;
         display_blink <= 5'h00;
      end else begin
         run_lamp <= drive_running;
         direction_lamp <= drive_reverse;
         case (eff_source)
            `SRC_PANEL: control_source_lamp <= 1'b0;
            `SRC_TERMINAL: control_source_lamp <= 1'b1;
            default: control_source_lamp <= slow_blink;
         endcase
         // Fault outranks tuning, tuning outranks torque mode
         if (drive_fault) begin
            tune_torque_lamp <= fast_blink;
         end else if (auto_tuning) begin
            tune_torque_lamp <= slow_blink;
         end else begin
            tune_torque_lamp <= torque_mode;
         end
         display_blink <= 5'h00;
         case (state)
            ST_VIEW: display_digits <= drive_fault ? fault_code : status_value;
            ST_GROUP: display_digits <= {16'h0000, group};
            ST_CODE: display_digits <= {8'h00, group, 4'h0, code};
            ST_VALUE: begin
               display_digits <= edit_value;
               if (!locked) begin
                  display_blink <= 5'h01 << edit_digit;
               end
            end
            default: display_digits <= 20'h00000;
         endcase
      end
   end
endmodule

// file: panel_op_model.sv
// Keypad operator model that presses one key at a time
`timescale 1ns/1ns
module keypad_operator (
   input wire clk,
   output reg [7:0] keys
);
   // Released keys read low
   initial begin
      keys = 8'h00;
   end
   // Terminal commands come through input terminals, never these keys
   // One press, held past the synchroniser, then a pause
   task automatic press(input integer k);
      @(posedge clk);
      keys[k] <= 1'h1;
      repeat (6) @(posedge clk);
      keys[k] <= 1'h0;
      repeat (6) @(posedge clk);
   endtask
endmodule

// file: panel_logic_sva.sv
// Checker for the operator panel port behaviour
`timescale 1ns/1ns
`include "panel_consts.vh"
module panel_logic_sva #(
   parameter FAST_HALF = 2
) (
   input wire clk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire drive_running,
   input wire drive_fault,
   input wire torque_mode,
   input wire auto_tuning,
   input wire run_lamp,
   input wire control_source_lamp,
   input wire tune_torque_lamp,
   input wire [4:0] display_blink,
   input wire start_request,
   input wire param_write,
   input wire [1:0] active_source
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   reg [7:0] still_cnt; // Fault cycles with a steady torque lamp
   reg lamp_q; // Torque lamp one cycle back
   // Count how long the lamp stays put during a fault
   always @(posedge clk) begin
      lamp_q <= tune_torque_lamp;
      if (sys_rst || !drive_fault || tune_torque_lamp != lamp_q)
         still_cnt <= 8'h00;
      else
         still_cnt <= still_cnt + 8'h01;
   end
   property p_run_lamp;
      (drive_running == $past(drive_running))[*2] |-> run_lamp == drive_running;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_ready_setup;
      psel && !penable |=> pready;
   endproperty
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   property p_start_panel;
      start_request |-> active_source == `SRC_PANEL && !drive_fault;
   endproperty
   property p_start_pulse;
      start_request |=> !start_request;
   endproperty
   property p_term_lamp;
      (active_source == `SRC_TERMINAL)[*3] |-> control_source_lamp;
   endproperty
   property p_panel_lamp;
      (active_source == `SRC_PANEL)[*3] |-> !control_source_lamp;
   endproperty
   property p_blink_onehot;
      $onehot0(display_blink);
   endproperty
   property p_torque_lamp;
      (torque_mode && !drive_fault && !auto_tuning)[*3] |-> tune_torque_lamp;
   endproperty
   property p_fault_fast;
      still_cnt < FAST_HALF + 4;
   endproperty
   a_run_lamp: assert property (p_run_lamp) else $error("run lamp wrong");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
   a_ready_setup: assert property (p_ready_setup) else $error("pready late");
   a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
   a_start_panel: assert property (p_start_panel) else $error("bad start");
   a_start_pulse: assert property (p_start_pulse) else $error("start long");
   a_term_lamp: assert property (p_term_lamp) else $error("source lamp off");
   a_panel_lamp: assert property (p_panel_lamp) else $error("source lamp on");
   a_blink_onehot: assert property (p_blink_onehot) else $error("blink digits");
   a_torque_lamp: assert property (p_torque_lamp) else $error("torque lamp");
   a_fault_fast: assert property (p_fault_fast) else $error("fault blink slow");
   c_start: cover property (start_request);
   c_store: cover property (param_write);
   c_err: cover property (pslverr);
endmodule

// file: drive_operator_panel_logic_tb_top.sv
// Testbench for the operator panel logic
`timescale 1ns/1ns
`include "panel_consts.vh"
module drive_operator_panel_logic_tb_top;
   logic clk, sys_rst, psel, penable, pwrite, e;
   logic [7:0] paddr, pw_addr;
   logic [31:0] pwdata, rd, ev;
   logic drive_running, drive_reverse, drive_fault, torque_mode, auto_tuning;
   logic [19:0] status_value, fault_code, pw_data;
   logic [4:0] saved_view;
   wire [31:0] prdata;
   wire pready, pslverr, run_lamp, control_source_lamp, direction_lamp, tune_torque_lamp;
   wire [19:0] display_digits, param_data;
   wire [4:0] display_blink, view_index;
   wire start_request, stop_request, fault_reset, direction_toggle, param_write;
   wire [1:0] active_source;
   wire [7:0] param_addr, keys;
   wire [1:0] lamps = {tune_torque_lamp, control_source_lamp};
   integer err_total = 0, check_count = 0, cyc = 0, i, n;
   integer n_start = 0, n_stop = 0, n_freset = 0, n_dir = 0, n_pw = 0;
   keypad_operator op (.clk(clk), .keys(keys));
   panel_logic #(.SLOW_HALF(8), .FAST_HALF(2)) uut (.*,
      .menu_key(keys[`KEY_MENU]), .enter_key(keys[`KEY_ENTER]), .up_key(keys[`KEY_UP]),
      .down_key(keys[`KEY_DOWN]), .shift_key(keys[`KEY_SHIFT]), .run_key(keys[`KEY_RUN]),
      .halt_reset_key(keys[`KEY_HALT]), .multifunction_key(keys[`KEY_MULTI]));
   // Clock at 50 ns
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Pulse counters, store capture and hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_start <= n_start + start_request;
      n_stop <= n_stop + stop_request;
      n_freset <= n_freset + fault_reset;
      n_dir <= n_dir + direction_toggle;
      n_pw <= n_pw + param_write;
      if (param_write === 1'h1) begin
         pw_addr <= param_addr;
         pw_data <= param_data;
      end
      if (cyc == 8000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
      check_count++;
      if (seen !== x) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, x, seen);
      end
   endtask
   // One APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer k;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k == 20) err_total++;
      rd = prdata;
      e = pslverr;
      @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      check(nm, rd & m, x);
   endtask
   // Count lamp changes over 40 cycles after settling
   task automatic toggles(input integer w, output integer t);
      logic p;
      repeat (4) @(posedge clk);
      p = lamps[w];
      t = 0;
      repeat (40) begin
         @(posedge clk);
         if (lamps[w] !== p) t++;
         p = lamps[w];
      end
   endtask
   // Main sequence
   initial begin
      sys_rst = 1'h1;
      {psel, penable, pwrite, paddr, pwdata} = 0;
      {drive_running, drive_reverse, drive_fault, torque_mode, auto_tuning} = 0;
      status_value = 20'h12345;
      fault_code = 20'h000E1;
      saved_view = 5'h03;
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (3) @(posedge clk);
      check("view_index", view_index, 5'h03);
      check("display", display_digits, 20'h12345);
      rdm("config", `REG_CONFIG, 32'hFFFFFFFF, `CFG_RESET);
      rdm("stop_mask", `REG_STOP_MASK, 32'hFFFFFFFF, `STOP_MASK_RESET);
      apb(1'h0, 8'hFC, 32'h0);
      check("unmapped_err", e, 1'h1);
      drive_running <= 1'h1;
      drive_reverse <= 1'h1;
      repeat (4) @(posedge clk);
      check("run_lamp", run_lamp, 1'h1);
      check("dir_lamp", direction_lamp, 1'h1);
      drive_running <= 1'h0;
      drive_reverse <= 1'h0;
      for (i = 0; i < 3; i++) begin
         wr(`REG_CONFIG, i);
         toggles(0, n);
         check("active_source", active_source, i);
         check("src_lamp_blink", n > 1, i == 2);
         if (i < 2) check("src_lamp", control_source_lamp, i);
      end
      wr(`REG_CONFIG, 32'h1);
      op.press(`KEY_RUN);
      check("start_term", n_start, 0);
      drive_running <= 1'h1;
      op.press(`KEY_HALT);
      check("stop_scope0", n_stop, 0);
      wr(`REG_CONFIG, 32'h101);
      op.press(`KEY_HALT);
      check("stop_scope1", n_stop, 1);
      drive_running <= 1'h0;
      wr(`REG_CONFIG, 32'h0);
      op.press(`KEY_RUN);
      check("start_panel", n_start, 1);
      wr(`REG_CONFIG, 32'h20);
      op.press(`KEY_MULTI);
      check("dir_toggle", n_dir, 1);
      wr(`REG_CONFIG, 32'h11);
      op.press(`KEY_MULTI);
      check("src_override", active_source, `SRC_PANEL);
      op.press(`KEY_MULTI);
      check("src_restore", active_source, `SRC_TERMINAL);
      wr(`REG_CONFIG, 32'h0);
      torque_mode <= 1'h1;
      toggles(1, n);
      check("torque_lamp", {n == 0, tune_torque_lamp}, 2'h3);
      auto_tuning <= 1'h1;
      toggles(1, n);
      check("tune_slow", n > 2 && n < 8, 1'h1);
      drive_fault <= 1'h1;
      toggles(1, n);
      check("fault_fast", n > 11, 1'h1);
      check("fault_code", display_digits, 20'h000E1);
      op.press(`KEY_HALT);
      check("fault_reset", n_freset, 1);
      {drive_fault, auto_tuning, torque_mode} <= 3'h0;
      wr(`REG_STOP_MASK, 32'h1001);
      op.press(`KEY_SHIFT);
      check("stop_view", view_index, 5'h0C);
      op.press(`KEY_SHIFT);
      check("stop_wrap", view_index, 5'h00);
      drive_running <= 1'h1;
      wr(`REG_RUN_MASK, 32'h100);
      for (i = 0; i < 4; i++) op.press(`KEY_SHIFT);
      check("run_default", view_index, 5'h04);
      op.press(`KEY_SHIFT);
      check("run_mask", view_index, 5'h08);
      op.press(`KEY_SHIFT);
      check("run_wrap", view_index, 5'h00);
      drive_running <= 1'h0;
      op.press(`KEY_MENU);
      rdm("to_group", `REG_STATUS, 32'hF, 32'h2);
      op.press(`KEY_UP);
      rdm("group_up", `REG_STATUS, 32'hF000, 32'h1000);
      op.press(`KEY_ENTER);
      op.press(`KEY_ENTER);
      rdm("to_value", `REG_STATUS, 32'h000F000F, 32'h8);
      check("edit_blink", display_blink, 5'h01);
      rdm("loaded", `REG_EDIT, 32'hFFFFFFFF, 32'h0);
      ev = 32'h1;
      op.press(`KEY_UP);
      rdm("edit_up", `REG_EDIT, 32'hFFFFFFFF, ev);
      op.press(`KEY_ENTER);
      check("store_count", n_pw, 1);
      check("store_addr", pw_addr, 8'h10);
      check("store_data", pw_data, ev[19:0]);
      rdm("next_code", `REG_STATUS, 32'h000F000F, 32'h10004);
      op.press(`KEY_DOWN);
      op.press(`KEY_ENTER);
      rdm("stored", `REG_EDIT, 32'hFFFFFFFF, ev);
      op.press(`KEY_SHIFT);
      check("digit1_blink", display_blink, 5'h02);
      op.press(`KEY_UP);
      op.press(`KEY_MENU);
      check("discard", n_pw, 1);
      rdm("same_code", `REG_STATUS, 32'h000F000F, 32'h4);
      wr(`REG_LOCK, 32'h2);
      op.press(`KEY_ENTER);
      check("lock_blink", display_blink, 5'h00);
      op.press(`KEY_UP);
      rdm("lock_edit", `REG_EDIT, 32'hFFFFFFFF, ev);
      op.press(`KEY_ENTER);
      check("lock_store", n_pw, 1);
      for (i = 0; i < 3; i++) begin
         apb(1'h0, `REG_STATUS, 32'h0);
         if (rd[3:0] !== 4'h1) op.press(`KEY_MENU);
      end
      rdm("to_view", `REG_STATUS, 32'hF, 32'h1);
      print_verdict();
   end
endmodule
bind panel_logic panel_logic_sva #(.FAST_HALF(FAST_HALF)) chk (.*);
